//--- icc_top.v
// four-channel input capture block with an AXI4-Lite register slave
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "icc_defines.vh"

module icc_top (
	// clock and reset
	input  wire        clk_in,
	input  wire        resetn_in,
	// axi4-lite write address and data
	input  wire        s_axi_awvalid_in,
	output wire        s_axi_awready_out,
	input  wire [11:0] s_axi_awaddr_in,
	input  wire        s_axi_wvalid_in,
	output wire        s_axi_wready_out,
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	// axi4-lite write response
	output wire        s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	output wire [1:0]  s_axi_bresp_out,
	// axi4-lite read
	input  wire        s_axi_arvalid_in,
	output wire        s_axi_arready_out,
	input  wire [11:0] s_axi_araddr_in,
	output wire        s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	output wire [31:0] s_axi_rdata_out,
	output wire [1:0]  s_axi_rresp_out,
	// capture pins, channels 1, 2, 7, 8
	input  wire [3:0]  cap_pin_in,
	// timebases
	input  wire [15:0] timebase_a_count_in,
	input  wire [15:0] timebase_b_count_in,
	input  wire        timebase_a_run_in,
	input  wire        timebase_b_run_in,
	// power state
	input  wire        sleep_in,
	input  wire        idle_in,
	// interrupts and wake-up
	output wire [3:0]  capture_irq_flag_out,
	output wire [3:0]  capture_irq_out,
	output wire        wake_out
);

	// ----------------------------------------------------------------
	// bus slave state
	// ----------------------------------------------------------------
	reg        awready_q;
	reg        wready_q;
	reg        bvalid_q;
	reg [1:0]  bresp_q;
	reg [9:0]  wr_idx_q;
	reg [15:0] wdata_q;
	reg [1:0]  wstrb_q;
	reg        arready_q;
	reg        rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0]  rresp_q;
	reg [3:0]  irq_en_q;
	reg        wake_q;

	wire       aw_take = s_axi_awvalid_in & awready_q;
	wire       w_take  = s_axi_wvalid_in & wready_q;
	wire       ar_take = s_axi_arvalid_in & arready_q;
	wire       wr_go   = ~awready_q & ~wready_q & ~bvalid_q;
	wire [9:0] rd_idx  = s_axi_araddr_in[11:2];

	// per-channel views driven from the generate loop
	wire [3:0]  rise_w;
	wire [3:0]  fall_w;
	wire [3:0]  flag_w;
	wire [3:0]  wake_w;
	wire [63:0] ctrl_rd_w;
	wire [63:0] head_w;

	// ----------------------------------------------------------------
	// write and read decode
	// ----------------------------------------------------------------
	reg [3:0] ctrl_we;
	reg [3:0] pop;
	reg       flag_we;
	reg       en_we;
	reg       wr_hit;
	reg [31:0] rd_mux;
	reg       rd_hit;

	always @* begin
		ctrl_we = 4'h0;
		flag_we = 1'b0;
		en_we   = 1'b0;
		wr_hit  = 1'b1;
		case (wr_idx_q)
			`ICC_IDX_CTRL_CH1: ctrl_we[0] = wr_go;
			`ICC_IDX_CTRL_CH2: ctrl_we[1] = wr_go;
			`ICC_IDX_CTRL_CH7: ctrl_we[2] = wr_go;
			`ICC_IDX_CTRL_CH8: ctrl_we[3] = wr_go;
			`ICC_IDX_IRQ_FLAG: flag_we    = wr_go;
			`ICC_IDX_IRQ_EN:   en_we      = wr_go;
			// buffers are read-only: writes are dropped with OKAY
			`ICC_IDX_FIFO_CH1, `ICC_IDX_FIFO_CH2,
			`ICC_IDX_FIFO_CH7, `ICC_IDX_FIFO_CH8: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always @* begin
		pop    = 4'h0;
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (rd_idx)
			`ICC_IDX_FIFO_CH1: begin
				rd_mux = {16'h0000, head_w[15:0]};
				pop[0] = ar_take;
			end
			`ICC_IDX_FIFO_CH2: begin
				rd_mux = {16'h0000, head_w[31:16]};
				pop[1] = ar_take;
			end
			`ICC_IDX_FIFO_CH7: begin
				rd_mux = {16'h0000, head_w[47:32]};
				pop[2] = ar_take;
			end
			`ICC_IDX_FIFO_CH8: begin
				rd_mux = {16'h0000, head_w[63:48]};
				pop[3] = ar_take;
			end
			`ICC_IDX_CTRL_CH1: rd_mux = {16'h0000, ctrl_rd_w[15:0]};
			`ICC_IDX_CTRL_CH2: rd_mux = {16'h0000, ctrl_rd_w[31:16]};
			`ICC_IDX_CTRL_CH7: rd_mux = {16'h0000, ctrl_rd_w[47:32]};
			`ICC_IDX_CTRL_CH8: rd_mux = {16'h0000, ctrl_rd_w[63:48]};
			`ICC_IDX_IRQ_FLAG: rd_mux = {28'h000_0000, flag_w};
			`ICC_IDX_IRQ_EN:   rd_mux = {28'h000_0000, irq_en_q};
			default:           rd_hit = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// axi4-lite handshakes
	// ----------------------------------------------------------------
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= `ICC_RESP_OKAY;
			wr_idx_q  <= 10'h000;
			wdata_q   <= 16'h0000;
			wstrb_q   <= 2'h0;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `ICC_RESP_OKAY;
			irq_en_q  <= 4'h0;
			wake_q    <= 1'b0;
		end else begin
			if (aw_take) begin
				wr_idx_q  <= s_axi_awaddr_in[11:2];
				awready_q <= 1'b0;
			end
			if (w_take) begin
				wdata_q  <= s_axi_wdata_in[15:0];
				wstrb_q  <= s_axi_wstrb_in[1:0];
				wready_q <= 1'b0;
			end
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
			end
			if (bvalid_q & s_axi_bready_in) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
			if (ar_take) begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rdata_q   <= rd_mux;
				rresp_q   <= rd_hit ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
			end
			if (rvalid_q & s_axi_rready_in) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
			if (en_we & wstrb_q[0]) begin
				irq_en_q <= wdata_q[3:0];
			end
			wake_q <= |wake_w;
		end
	end

	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out  = wready_q;
	assign s_axi_bvalid_out  = bvalid_q;
	assign s_axi_bresp_out   = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out  = rvalid_q;
	assign s_axi_rdata_out   = rdata_q;
	assign s_axi_rresp_out   = rresp_q;
	assign wake_out          = wake_q;
	assign capture_irq_flag_out = flag_w;

	// ----------------------------------------------------------------
	// capture channels
	// ----------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < 4; c = c + 1) begin : gen_ch
			reg [2:0]  mode_q;
			reg [1:0]  icnt_q;
			reg        tsel_q;
			reg        sidl_q;
			reg        ov_q;
			reg        lock_q;
			reg [2:0]  cnt_q;
			reg [3:0]  pre_q;
			reg [1:0]  evc_q;
			reg        flag_q;
			reg        irq_q;
			reg [15:0] mem_q [0:3];
			integer    i;

			wire tb_run = tsel_q ? timebase_a_run_in : timebase_b_run_in;
			// full function needs an awake cpu, or in idle a running timebase with sidl_q clear
			wire full_ok = ~sleep_in & ~(idle_in & (~tb_run | sidl_q));
			wire [15:0] tb_val = tsel_q ? timebase_a_count_in
			                            : timebase_b_count_in;
			wire pre_cnt = (mode_q == `ICC_M_RISE4) | (mode_q == `ICC_M_RISE16);
			wire [3:0] pre_last = (mode_q == `ICC_M_RISE4) ? `ICC_PRE4_LAST
			                                               : `ICC_PRE16_LAST;
			reg  edge_hit;
			wire cap_evt  = full_ok & edge_hit;
			// mode 111 is a pin interrupt only and never stores a count
			wire pin_evt  = (mode_q == `ICC_M_IRQ_ONLY) & rise_w[c];
			wire do_pop   = pop[c] & (cnt_q != 3'h0);
			wire full     = (cnt_q == `ICC_FIFO_DEPTH);
			wire store    = cap_evt & ~lock_q & (~full | do_pop);
			wire ov_evt   = cap_evt & ~lock_q & full & ~do_pop &
			                (mode_q != `ICC_M_BOTH);
			wire [1:0] wr_pos = do_pop ? cnt_q[1:0] - 2'h1 : cnt_q[1:0];
			wire evc_done = (evc_q == icnt_q);
			wire irq_evt  = pin_evt | (cap_evt &
			                ((mode_q == `ICC_M_BOTH) | evc_done));
			wire ctrl_b0  = ctrl_we[c] & wstrb_q[0];
			wire ctrl_b1  = ctrl_we[c] & wstrb_q[1];
			wire flag_clr = flag_we & wstrb_q[0] & wdata_q[c];

			always @* begin
				edge_hit = 1'b0;
				case (mode_q)
					`ICC_M_BOTH:   edge_hit = rise_w[c] | fall_w[c];
					`ICC_M_FALL:   edge_hit = fall_w[c];
					`ICC_M_RISE:   edge_hit = rise_w[c];
					`ICC_M_RISE4:  edge_hit = rise_w[c] & (pre_q == pre_last);
					`ICC_M_RISE16: edge_hit = rise_w[c] & (pre_q == pre_last);
					default:       edge_hit = 1'b0;
				endcase
			end

			icc_edge u_edge (
				.clk_in    (clk_in),
				.resetn_in (resetn_in),
				.pin_in    (cap_pin_in[c]),
				.rise_out  (rise_w[c]),
				.fall_out  (fall_w[c])
			);

			always @(posedge clk_in or negedge resetn_in) begin
				if (!resetn_in) begin
					mode_q <= `ICC_MODE_RST;
					icnt_q <= `ICC_ICNT_RST;
					tsel_q <= `ICC_TSEL_RST;
					sidl_q <= `ICC_SIDL_RST;
					ov_q   <= 1'b0;
					lock_q <= 1'b0;
					cnt_q  <= 3'h0;
					pre_q  <= 4'h0;
					evc_q  <= 2'h0;
					flag_q <= 1'b0;
					irq_q  <= 1'b0;
					for (i = 0; i < 4; i = i + 1) begin
						mem_q[i] <= 16'h0000;
					end
				end else begin
					if (ctrl_b0) begin
						mode_q <= wdata_q[`ICC_F_MODE];
						icnt_q <= wdata_q[`ICC_F_ICNT];
						tsel_q <= wdata_q[`ICC_F_TSEL];
					end
					if (ctrl_b1) begin
						sidl_q <= wdata_q[`ICC_F_SIDL];
					end
					// prescaler and event count restart while off
					if (mode_q == `ICC_M_OFF) begin
						pre_q <= 4'h0;
						evc_q <= 2'h0;
					end else begin
						if (pre_cnt & full_ok & rise_w[c]) begin
							pre_q <= (pre_q == pre_last) ? 4'h0 : pre_q + 4'h1;
						end
						if (cap_evt & (mode_q != `ICC_M_BOTH)) begin
							evc_q <= evc_done ? 2'h0 : evc_q + 2'h1;
						end
					end
					// shift forward, then append behind the survivors
					if (do_pop) begin
						for (i = 0; i < 3; i = i + 1) begin
							mem_q[i] <= mem_q[i + 1];
						end
					end
					if (store) begin
						mem_q[wr_pos] <= tb_val;
					end
					if (store & ~do_pop) begin
						cnt_q <= cnt_q + 3'h1;
					end else if (do_pop & ~store) begin
						cnt_q <= cnt_q - 3'h1;
					end
					// set wins over a clear written in the same cycle
					if (ov_evt) begin
						ov_q   <= 1'b1;
						lock_q <= 1'b1;
					end else begin
						if (ctrl_b0 & ~wdata_q[`ICC_F_OV]) begin
							ov_q <= 1'b0;
						end
						if (do_pop & (cnt_q == 3'h1)) begin
							lock_q <= 1'b0;
						end
					end
					if (irq_evt) begin
						flag_q <= 1'b1;
					end else if (flag_clr) begin
						flag_q <= 1'b0;
					end
					irq_q <= (flag_q | irq_evt) & irq_en_q[c];
				end
			end

			assign flag_w[c] = flag_q;
			assign capture_irq_out[c] = irq_q;
			assign wake_w[c] = pin_evt & irq_en_q[c] & (sleep_in | idle_in);
			assign head_w[16*c +: 16] = mem_q[0];
			assign ctrl_rd_w[16*c +: 16] = {2'h0, sidl_q, 5'h00, tsel_q, icnt_q,
			                                ov_q, (cnt_q != 3'h0), mode_q};
		end
	endgenerate

endmodule

`default_nettype wire

//--- icc_defines.vh
// constants shared by the input capture channel block
`ifndef ICC_DEFINES_VH
`define ICC_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ICC_IDX_FIFO_CH1  10'h140
`define ICC_IDX_CTRL_CH1  10'h142
`define ICC_IDX_FIFO_CH2  10'h144
`define ICC_IDX_CTRL_CH2  10'h146
`define ICC_IDX_FIFO_CH7  10'h158
`define ICC_IDX_CTRL_CH7  10'h15a
`define ICC_IDX_FIFO_CH8  10'h15c
`define ICC_IDX_CTRL_CH8  10'h15e
`define ICC_IDX_IRQ_FLAG  10'h160
`define ICC_IDX_IRQ_EN    10'h162

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ICC_F_MODE        2:0
`define ICC_F_BNE         3
`define ICC_F_OV          4
`define ICC_F_ICNT        6:5
`define ICC_F_TSEL        7
`define ICC_F_SIDL        13
`define ICC_CTRL_RST      16'h0000
`define ICC_MODE_RST      3'h0
`define ICC_ICNT_RST      2'h0
`define ICC_TSEL_RST      1'b0
`define ICC_SIDL_RST      1'b0

// ----------------------------------------------------------------
// capture modes
// ----------------------------------------------------------------
`define ICC_M_OFF         3'h0
`define ICC_M_BOTH        3'h1
`define ICC_M_FALL        3'h2
`define ICC_M_RISE        3'h3
`define ICC_M_RISE4       3'h4
`define ICC_M_RISE16      3'h5
`define ICC_M_IRQ_ONLY    3'h7

// ----------------------------------------------------------------
// counts and bus answers
// ----------------------------------------------------------------
`define ICC_PRE4_LAST     4'h3
`define ICC_PRE16_LAST    4'hf
`define ICC_FIFO_DEPTH    3'h4
`define ICC_RESP_OKAY     2'h0
`define ICC_RESP_SLVERR   2'h2

`endif

//--- icc_edge.v
// pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ns
`default_nettype none

module icc_edge (
	// clock and reset
	input  wire clk_in,
	input  wire resetn_in,
	// pin and edge pulses
	input  wire pin_in,
	output wire rise_out,
	output wire fall_out
);

	reg sync1_q;
	reg sync2_q;
	reg last_q;

	// only sync2_q and last_q feed the edge logic
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			last_q  <= 1'b0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			last_q  <= sync2_q;
		end
	end

	assign rise_out = sync2_q & ~last_q;
	assign fall_out = ~sync2_q & last_q;

endmodule

`default_nettype wire

//--- icc_chk_properties.sv
// concurrent checks on the bus and interrupt ports of the capture block
`timescale 1ns/1ns
`default_nettype none
`include "icc_defines.vh"

module icc_chk (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        resetn_in,
	// register bus
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wready_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0]  s_axi_rresp_out,
	// interrupts and wake-up
	input wire logic [3:0]  capture_irq_flag_out,
	input wire logic [3:0]  capture_irq_out,
	input wire logic        wake_out
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	chk_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read address not answered");
	chk_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
		s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
		else $error("read answer changed before taken");
	chk_read_busy: assert property (s_axi_rvalid_out |->
		!s_axi_arready_out && s_axi_rdata_out[31:16] == 16'h0000)
		else $error("read busy or upper bits wrong");
	chk_err_zero: assert property (s_axi_rvalid_out && s_axi_rresp_out == `ICC_RESP_SLVERR |->
		s_axi_rdata_out == 32'h0000_0000)
		else $error("refused read carries data");
	chk_write_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && !s_axi_awready_out && !s_axi_wready_out)
		else $error("write response dropped early");
	chk_write_done: assert property (s_axi_bvalid_out && s_axi_bready_in |=>
		!s_axi_bvalid_out ##[0:1] (s_axi_awready_out && s_axi_wready_out))
		else $error("write channel not freed");
	chk_irq_flag: assert property ($rose(capture_irq_out[0]) |-> capture_irq_flag_out[0])
		else $error("interrupt without flag");
	chk_wake_pulse: assert property (wake_out |=> !wake_out)
		else $error("wake request longer than one cycle");

	cover property (wake_out);
	cover property (capture_irq_out[0]);
	cover property (s_axi_rvalid_out && s_axi_rresp_out == `ICC_RESP_SLVERR);
endmodule
`default_nettype wire

//--- icc_pin_model.sv
// capture pin driver standing in for the external signal source
`timescale 1ns/1ns
`default_nettype none

module icc_pin_model (
	// clock
	input wire logic       clk_in,
	// capture pins
	output var logic [3:0] pin_out
);
	// ----------------------------------------
	// edge generator
	// ----------------------------------------
	initial pin_out = 4'h0;

	// edges four cycles apart so the two-flop sync sees every level
	// all four pins move together; channels left off ignore them
	task automatic tog(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk_in);
			pin_out <= ~pin_out;
		end
		repeat (6) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the input capture block
`timescale 1ns/1ns
`default_nettype none
`include "icc_defines.vh"

module testbench;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [11:0] a_f1 = {`ICC_IDX_FIFO_CH1, 2'b00};
	localparam logic [11:0] a_c1 = {`ICC_IDX_CTRL_CH1, 2'b00};
	localparam logic [11:0] a_fl = {`ICC_IDX_IRQ_FLAG, 2'b00};
	localparam logic [11:0] a_en = {`ICC_IDX_IRQ_EN, 2'b00};
	localparam logic [11:0] a_c2 = {`ICC_IDX_CTRL_CH2, 2'b00};
	localparam logic [11:0] a_c7 = {`ICC_IDX_CTRL_CH7, 2'b00};
	localparam logic [11:0] a_f7 = {`ICC_IDX_FIFO_CH7, 2'b00};
	localparam logic [11:0] a_c8 = {`ICC_IDX_CTRL_CH8, 2'b00};
	localparam logic [11:0] a_f8 = {`ICC_IDX_FIFO_CH8, 2'b00};
	logic        clk_in = 1'b0;
	logic        rst_n;
	logic        aw, w, br, ar, rr;
	logic [11:0] awa, ara;
	logic [31:0] wd;
	logic [3:0]  st;
	logic [15:0] ca, cb;
	logic        ra, rb, slp, idl;
	wire         awr, wrr, bv, arr, rv, wake;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [3:0]  pin, flg, irq;
	logic [31:0] d;
	logic [1:0]  rsp;
	logic [2:0]  md [4] = '{`ICC_M_FALL, `ICC_M_RISE, `ICC_M_RISE4, `ICC_M_RISE16};
	int          np [4] = '{1, 1, 4, 16};
	int          err_total = 0, compares = 0, wakes = 0;

	icc_pin_model i_pin (.clk_in(clk_in), .pin_out(pin));
	icc_top i_dut (
		.clk_in(clk_in), .resetn_in(rst_n),
		.s_axi_awvalid_in(aw), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
		.s_axi_wvalid_in(w), .s_axi_wready_out(wrr), .s_axi_wdata_in(wd),
		.s_axi_wstrb_in(st), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
		.s_axi_bresp_out(bresp), .s_axi_arvalid_in(ar), .s_axi_arready_out(arr),
		.s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .cap_pin_in(pin),
		.timebase_a_count_in(ca), .timebase_b_count_in(cb), .timebase_a_run_in(ra),
		.timebase_b_run_in(rb), .sleep_in(slp), .idle_in(idl),
		.capture_irq_flag_out(flg), .capture_irq_out(irq), .wake_out(wake)
	);

	initial begin
		forever #10 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		if (wake === 1'b1)
			wakes++;
	end

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	// waits are open-ended: only the watchdog ends a hung transfer
	task automatic put_s(input logic [11:0] a, input logic [15:0] v, input logic [3:0] s);
		@(posedge clk_in);
		aw <= 1'b1;
		w <= 1'b1;
		awa <= a;
		wd <= {16'h0000, v};
		st <= s;
		br <= 1'b1;
		do begin
			@(posedge clk_in);
			if (awr) aw <= 1'b0;
			if (wrr) w <= 1'b0;
		end while (bv !== 1'b1);
		rsp = bresp;
		br <= 1'b0;
	endtask

	task automatic put(input logic [11:0] a, input logic [15:0] v);
		put_s(a, v, 4'hf);
	endtask

	task automatic get(input logic [11:0] a);
		@(posedge clk_in);
		ar <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arr) ar <= 1'b0;
		end while (rv !== 1'b1);
		d = rdata;
		rsp = rresp;
		rr <= 1'b0;
	endtask

	task automatic ck(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	task give_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		rst_n <= 1'b0;
		{aw, w, br, ar, rr, slp, idl} <= 7'h00;
		{ra, rb} <= 2'h3;
		{awa, ara} <= 24'h00_0000;
		wd <= 32'h0000_0000;
		st <= 4'hf;
		ca <= 16'h1111;
		cb <= 16'h2222;
		repeat (12) @(posedge clk_in);
		rst_n <= 1'b1;
		get(a_c1);
		ck("ctrl", `ICC_CTRL_RST, d[15:0]);
		get(12'h7fc);
		ck("resp", 16'(`ICC_RESP_SLVERR), 16'(rsp));
		// upper lane only: stop-in-idle set, mode left alone
		put_s(a_c1, 16'h2003, 4'h2);
		put(a_f1, 16'h1234);
		ck("fifo wr", 16'(`ICC_RESP_OKAY), 16'(rsp));
		put(12'h7fc, 16'h0000);
		ck("bresp", 16'(`ICC_RESP_SLVERR), 16'(rsp));
		get(a_c1);
		ck("lane", 16'h2000, d[15:0]);
		$display("reset test ended");
		// odd passes use timebase a, even ones the default b
		for (int m = 0; m < 4; m++) begin
			put(a_c1, {8'h00, m[0], 4'h0, md[m]});
			i_pin.tog(2 * np[m] - 2);
			get(a_c1);
			ck("early", 16'h0000, 16'(d[3]));
			i_pin.tog(2);
			get(a_f1);
			ck("count", m[0] ? ca : cb, d[15:0]);
			put(a_c1, 16'h0000);
		end
		ck("irq", 16'h0001, {irq[0], flg[0]});
		$display("mode test ended");
		put(a_c1, 16'(`ICC_M_RISE));
		for (int i = 1; i <= 5; i++) begin
			cb <= 16'(i);
			i_pin.tog(2);
		end
		get(a_c1);
		ck("status", 16'h0018, d[15:0] & 16'h0018);
		for (int i = 1; i <= 3; i++) begin
			get(a_f1);
			ck("order", 16'(i), d[15:0]);
		end
		cb <= 16'h0009;
		i_pin.tog(2);
		get(a_f1);
		ck("locked", 16'h0004, d[15:0]);
		i_pin.tog(2);
		get(a_f1);
		ck("drained", 16'h0009, d[15:0]);
		get(a_c1);
		ck("empty", 16'h0000, 16'(d[3]));
		put(a_c1, 16'h0000);
		$display("buffer test ended");
		put(a_fl, 16'h000f);
		// other channels: 110 stores nothing, 011 on timebase a
		ca <= 16'h4321;
		put(a_c2, 16'h0086);
		put(a_c7, 16'h0083);
		put(a_c8, 16'h0083);
		i_pin.tog(2);
		get(a_c2);
		ck("ch2", 16'h0086, d[15:0]);
		get(a_f7);
		ck("ch7", 16'h4321, d[15:0]);
		get(a_f8);
		ck("ch8", 16'h4321, d[15:0]);
		ck("flags", 16'h000c, 16'(flg));
		ck("gated", 16'h0000, 16'(irq));
		put(a_c2, 16'h0000);
		put(a_c7, 16'h0000);
		put(a_c8, 16'h0000);
		put(a_c1, 16'h0061);
		i_pin.tog(1);
		ck("edge", 16'h0001, 16'(flg[0]));
		i_pin.tog(5);
		get(a_c1);
		ck("nov", 16'h0000, 16'(d[4]));
		repeat (4) get(a_f1);
		put(a_c1, 16'h0000);
		put(a_fl, 16'h000f);
		put(a_en, 16'h0001);
		put(a_c1, 16'h0043);
		i_pin.tog(4);
		ck("n2", 16'h0000, {irq[0], flg[0]});
		i_pin.tog(2);
		ck("n3", 16'h0003, {irq[0], flg[0]});
		repeat (3) get(a_f1);
		$display("interrupt test ended");
		put(a_c1, 16'(`ICC_M_IRQ_ONLY));
		slp <= 1'b1;
		i_pin.tog(2);
		ck("wake", 16'h0001, 16'(wakes));
		put(a_c1, 16'(`ICC_M_RISE));
		i_pin.tog(2);
		slp <= 1'b0;
		get(a_c1);
		ck("sleep", 16'h0000, 16'(d[3]));
		idl <= 1'b1;
		rb <= 1'b0;
		i_pin.tog(2);
		get(a_c1);
		ck("stop", 16'h0000, 16'(d[3]));
		rb <= 1'b1;
		i_pin.tog(2);
		get(a_f1);
		ck("idle", cb, d[15:0]);
		put(a_c1, 16'h2003);
		i_pin.tog(2);
		get(a_c1);
		ck("sidl", 16'h2003, d[15:0]);
		put(a_c1, 16'h0083);
		ra <= 1'b0;
		i_pin.tog(2);
		get(a_c1);
		ck("tba", 16'h0083, d[15:0]);
		ra <= 1'b1;
		put(a_c1, 16'(`ICC_M_IRQ_ONLY));
		i_pin.tog(2);
		get(a_c1);
		ck("pin only", 16'h0007, d[15:0]);
		ck("wake2", 16'h0002, 16'(wakes));
		idl <= 1'b0;
		$display("power test ended");
		give_verdict();
	end

	initial begin
		#400000;
		err_total++;
		give_verdict();
	end
endmodule

bind icc_top icc_chk i_chk (
	.clk_in(clk_in), .resetn_in(resetn_in),
	.s_axi_awready_out(s_axi_awready_out), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
	.capture_irq_flag_out(capture_irq_flag_out), .capture_irq_out(capture_irq_out),
	.wake_out(wake_out)
);
`default_nettype wire
